// ==== hw/mdp_pkg.sv ====
package mdp_pkg;

	// ------------------------------------------------------------
	// Clock and time base
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int KEY_TIMEOUT_MS = 5000;
	localparam int WB_FAST_MS = 2000;
	localparam int WB_SLOW_MS = 7000;
	localparam int SHOW_UNIT_MS = 100;
	localparam int BLINK_MS = 500;

	// ------------------------------------------------------------
	// Values and display limits
	// ------------------------------------------------------------
	localparam int VAL_W = 16;
	localparam logic signed [15:0] DISP_MIN = 16'hFC19;
	localparam logic signed [15:0] DISP_MAX = 16'h270F;
	localparam logic signed [15:0] VAL_TOP = 16'h7FFF;
	localparam logic [15:0] ZERO16 = 16'h0000;

	// ------------------------------------------------------------
	// Display message codes
	// ------------------------------------------------------------
	localparam logic [2:0] MSG_VALUE = 3'h0;
	localparam logic [2:0] MSG_UPPER = 3'h1;
	localparam logic [2:0] MSG_UNDER = 3'h2;
	localparam logic [2:0] MSG_EXCESS = 3'h3;
	localparam logic [2:0] MSG_SENSOR = 3'h4;
	localparam logic [2:0] MSG_LABEL = 3'h5;

	// ------------------------------------------------------------
	// Configuration parameter addresses and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] CFG_SWING = 4'h0;
	localparam logic [3:0] CFG_SHOW = 4'h1;
	localparam logic [3:0] CFG_HOLD_MODE = 4'h2;
	localparam logic [3:0] CFG_RELAY_SRC = 4'h3;
	localparam logic [3:0] CFG_TARGET = 4'h4;
	localparam logic [3:0] CFG_KP_H = 4'h5;
	localparam logic [3:0] CFG_KI_H = 4'h6;
	localparam logic [3:0] CFG_KD_H = 4'h7;
	localparam logic [3:0] CFG_KP_C = 4'h8;
	localparam logic [3:0] CFG_KI_C = 4'h9;
	localparam logic [3:0] CFG_KD_C = 4'hA;
	localparam logic [3:0] CFG_FREE_ACC = 4'hB;
	localparam logic [15:0] RST_SWING = 16'h000A;
	localparam logic [15:0] RST_SHOW = 16'h0032;

	typedef enum logic [2:0] {
		MDP_BR_IDLE = 3'b001,
		MDP_BR_SHOW = 3'b010,
		MDP_BR_EDIT = 3'b100
	} mdp_browse_t;

endpackage

// ==== hw/mdp_peak_if.sv ====
interface mdp_peak_if;
	logic smp_vld;
	logic signed [15:0] smp_val;
	logic [15:0] swing;
	logic peak_stb;
	logic signed [15:0] peak_val;
	modport src (output smp_vld, output smp_val, output swing, input peak_stb, input peak_val);
	modport det (input smp_vld, input smp_val, input swing, output peak_stb, output peak_val);
endinterface

// ==== hw/mdp_peak.sv ====
module mdp_peak (
	input wire logic clk,
	input wire logic rst_n,
	mdp_peak_if.det pk
);
	logic signed [15:0] lo_q;
	logic signed [15:0] hi_q;
	logic rising_q;
	logic peak_stb_q;
	logic signed [15:0] peak_val_q;
	wire signed [17:0] v_x = 18'(pk.smp_val);
	wire signed [17:0] rise_lvl = 18'(lo_q) + 18'(pk.swing);
	wire signed [17:0] fall_lvl = 18'(hi_q) - 18'(pk.swing);
	wire rise_hit = !rising_q && (v_x >= rise_lvl);
	wire fall_hit = rising_q && (pk.smp_val <= hi_q) && (v_x <= fall_lvl);

	assign pk.peak_stb = peak_stb_q;
	assign pk.peak_val = peak_val_q;

	// ------------------------------------------------------------
	// Valley then crest tracking
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lo_q <= mdp_pkg::VAL_TOP;
			hi_q <= mdp_pkg::VAL_TOP;
			rising_q <= 1'b0;
			peak_stb_q <= 1'b0;
			peak_val_q <= mdp_pkg::ZERO16;
		end else begin
			peak_stb_q <= 1'b0;
			if (pk.smp_vld) begin
				if (rise_hit) begin
					rising_q <= 1'b1;
					hi_q <= pk.smp_val;
				end else if (!rising_q && pk.smp_val < lo_q) begin
					lo_q <= pk.smp_val;
				end else if (fall_hit) begin
					peak_stb_q <= 1'b1;
					peak_val_q <= hi_q;
					rising_q <= 1'b0;
					lo_q <= pk.smp_val;
				end else if (rising_q && pk.smp_val > hi_q) begin
					hi_q <= pk.smp_val;
				end
			end
		end
	end
endmodule

// ==== hw/mdp_pid.sv ====
module mdp_pid (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic step,
	input wire logic cooling,
	input wire logic signed [15:0] target,
	input wire logic signed [15:0] measured,
	input wire logic [15:0] kp,
	input wire logic [15:0] ki,
	input wire logic [15:0] kd,
	output logic [15:0] drive
);
	logic signed [16:0] err_prev_q;
	logic signed [31:0] acc_q;
	logic [15:0] drive_q;
	wire signed [16:0] err = cooling ? 17'(measured) - 17'(target) : 17'(target) - 17'(measured);
	wire signed [17:0] derr = 18'(err) - 18'(err_prev_q);
	wire signed [31:0] acc_d = (ki == mdp_pkg::ZERO16) ? 32'sd0 : acc_q + 32'(err);
	wire signed [47:0] p_t = 48'(err) * 48'($signed({1'b0, kp}));
	wire signed [47:0] i_t = 48'(acc_d) * 48'($signed({1'b0, ki}));
	wire signed [47:0] d_t = 48'(derr) * 48'($signed({1'b0, kd}));
	wire signed [47:0] sum = p_t + i_t + d_t;

	function automatic logic [15:0] clamp(input logic signed [47:0] x);
		if (x < 48'sd0)
			return mdp_pkg::ZERO16;
		else if (x > 48'sd65535)
			return 16'hFFFF;
		else
			return x[15:0];
	endfunction

	assign drive = drive_q;

	// ------------------------------------------------------------
	// One update per fresh measurement
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_prev_q <= '0;
			acc_q <= '0;
			drive_q <= mdp_pkg::ZERO16;
		end else if (step) begin
			err_prev_q <= err;
			acc_q <= acc_d;
			drive_q <= clamp(sum);
		end
	end
endmodule

// ==== hw/mdp_top.sv ====
// Functional notes
// - Above permissible range show upper overflow; below it show under-range message.
// - A detected sensor failure replaces the measurement with the fault message.
// - Wire break recognised within about two seconds, seven on slow terminals.
// - In range but outside -999 to 9999 shows the readout excess message.
// - Temperature inputs: linear only, nominal and permissible ranges identical.
// - Up or down key alternates threshold label and value on display.
// - Another press within 5 s advances; otherwise back to measurement.
// - Enter edits shown threshold only when free access is enabled.
// - Configuration writes never pause or interrupt ongoing measurement.
// - Every parameter is also writable remotely over the serial port.
// - Peak needs a rise then a fall of at least the minimum swing.
// - A recognised peak stays displayed for the programmed show duration.
// - New peak during show replaces it and restarts the duration counter.
// - Duration expiry without a new peak returns to the live value.
// - Hold mode with zero duration keeps the peak until escape.
// - Live tracking mode with zero duration disables peak holding.
// - Rightmost decimal point flashes while a peak is displayed.
// - Relay/LED outputs follow live or peak value, selectable.
// - Heating loop error is target minus measurement, cooling loop error measurement minus target, driven toward zero.
// - Two independent loops, heating and cooling, summing P, I and D.
// - Both loops share one target value.
// - A term whose parameter is zero is disabled.
// - Auto-tune loads only P, I, D of one loop, nothing else.
module mdp_top #(
	parameter int TICK_CYCLES = mdp_pkg::CYC_PER_MS,
	parameter int NUM_THR = 4,
	parameter int KEY_TIMEOUT_MS = mdp_pkg::KEY_TIMEOUT_MS,
	parameter int WB_FAST_MS = mdp_pkg::WB_FAST_MS,
	parameter int WB_SLOW_MS = mdp_pkg::WB_SLOW_MS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic meas_vld,
	input wire logic signed [15:0] meas_val,
	input wire logic above_perm,
	input wire logic below_perm,
	input wire logic above_nom,
	input wire logic below_nom,
	input wire logic temp_input,
	input wire logic wire_open,
	input wire logic slow_terminal,
	input wire logic key_up,
	input wire logic key_down,
	input wire logic key_enter,
	input wire logic key_esc,
	input wire logic [NUM_THR*16-1:0] thr_values,
	input wire logic local_wr,
	input wire logic [3:0] local_addr,
	input wire logic [15:0] local_data,
	input wire logic remote_wr,
	input wire logic [3:0] remote_addr,
	input wire logic [15:0] remote_data,
	input wire logic tune_load,
	input wire logic tune_cooling,
	input wire logic [15:0] tune_kp,
	input wire logic [15:0] tune_ki,
	input wire logic [15:0] tune_kd,
	output logic [2:0] disp_msg,
	output logic signed [15:0] disp_val,
	output logic [7:0] disp_thr_idx,
	output logic dp_right,
	output logic peak_shown,
	output logic edit_active,
	output logic sensor_fault,
	output logic signed [15:0] relay_val,
	output logic [15:0] heat_drive,
	output logic [15:0] cool_drive
);
	mdp_peak_if pk ();

	// ------------------------------------------------------------
	// Configuration store
	// ------------------------------------------------------------
	logic [15:0] swing_q;
	logic [15:0] show_q;
	logic hold_mode_q;
	logic relay_src_q;
	logic signed [15:0] target_q;
	logic free_acc_q;
	logic [15:0] kp_h_q, ki_h_q, kd_h_q, kp_c_q, ki_c_q, kd_c_q;

	// Remote wins a same-cycle collision; the local write is then lost
	wire cfg_wr = remote_wr | local_wr;
	wire [3:0] cfg_addr = remote_wr ? remote_addr : local_addr;
	wire [15:0] cfg_data = remote_wr ? remote_data : local_data;
	wire tune_h = tune_load & ~tune_cooling;
	wire tune_c = tune_load & tune_cooling;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			swing_q <= mdp_pkg::RST_SWING;
			show_q <= mdp_pkg::RST_SHOW;
			hold_mode_q <= 1'b0;
			relay_src_q <= 1'b0;
			target_q <= mdp_pkg::ZERO16;
			free_acc_q <= 1'b0;
		end else if (cfg_wr) begin
			case (cfg_addr)
				mdp_pkg::CFG_SWING: swing_q <= cfg_data;
				mdp_pkg::CFG_SHOW: show_q <= cfg_data;
				mdp_pkg::CFG_HOLD_MODE: hold_mode_q <= cfg_data[0];
				mdp_pkg::CFG_RELAY_SRC: relay_src_q <= cfg_data[0];
				mdp_pkg::CFG_TARGET: target_q <= cfg_data;
				mdp_pkg::CFG_FREE_ACC: free_acc_q <= cfg_data[0];
				default: ;
			endcase
		end
	end

	// Tuning result touches only the gains of the selected loop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			kp_h_q <= mdp_pkg::ZERO16;
			ki_h_q <= mdp_pkg::ZERO16;
			kd_h_q <= mdp_pkg::ZERO16;
			kp_c_q <= mdp_pkg::ZERO16;
			ki_c_q <= mdp_pkg::ZERO16;
			kd_c_q <= mdp_pkg::ZERO16;
		end else if (tune_h) begin
			kp_h_q <= tune_kp;
			ki_h_q <= tune_ki;
			kd_h_q <= tune_kd;
		end else if (tune_c) begin
			kp_c_q <= tune_kp;
			ki_c_q <= tune_ki;
			kd_c_q <= tune_kd;
		end else if (cfg_wr) begin
			if (cfg_addr == mdp_pkg::CFG_KP_H) kp_h_q <= cfg_data;
			if (cfg_addr == mdp_pkg::CFG_KI_H) ki_h_q <= cfg_data;
			if (cfg_addr == mdp_pkg::CFG_KD_H) kd_h_q <= cfg_data;
			if (cfg_addr == mdp_pkg::CFG_KP_C) kp_c_q <= cfg_data;
			if (cfg_addr == mdp_pkg::CFG_KI_C) ki_c_q <= cfg_data;
			if (cfg_addr == mdp_pkg::CFG_KD_C) kd_c_q <= cfg_data;
		end
	end

	// ------------------------------------------------------------
	// Millisecond tick and slower enables
	// ------------------------------------------------------------
	localparam int SHOW_MS = mdp_pkg::SHOW_UNIT_MS;
	localparam int BLINK_MS = mdp_pkg::BLINK_MS;
	logic [15:0] div_q;
	logic [6:0] deci_q;
	logic [8:0] blink_cnt_q;
	logic blink_q;
	wire ms_tick = (div_q == 16'(TICK_CYCLES - 1));
	wire deci_tick = ms_tick && (deci_q == 7'(SHOW_MS - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= mdp_pkg::ZERO16;
			deci_q <= '0;
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end else begin
			div_q <= ms_tick ? mdp_pkg::ZERO16 : div_q + 16'h0001;
			if (ms_tick) begin
				deci_q <= deci_tick ? 7'd0 : deci_q + 7'd1;
				if (blink_cnt_q == 9'(BLINK_MS - 1)) begin
					blink_cnt_q <= '0;
					blink_q <= ~blink_q;
				end else begin
					blink_cnt_q <= blink_cnt_q + 9'd1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Sensor fault watch
	// ------------------------------------------------------------
	// An open wire starves the converter, so silence beyond the limit counts as a break
	logic [12:0] quiet_q;
	logic fault_q;
	wire [12:0] wb_limit = slow_terminal ? 13'(WB_SLOW_MS) : 13'(WB_FAST_MS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet_q <= '0;
			fault_q <= 1'b0;
		end else if (wire_open) begin
			fault_q <= 1'b1;
		end else if (meas_vld) begin
			quiet_q <= '0;
			fault_q <= 1'b0;
		end else if (ms_tick && !fault_q) begin
			quiet_q <= quiet_q + 13'd1;
			if (quiet_q + 13'd1 >= wb_limit) fault_q <= 1'b1;
		end
	end
	assign sensor_fault = fault_q;

	// ------------------------------------------------------------
	// Measurement capture and range classes
	// ------------------------------------------------------------
	// Capture runs off meas_vld alone; cfg writes never gate it
	logic signed [15:0] live_q;
	logic upper_q, under_q;
	wire over_sel = temp_input ? above_nom : above_perm;
	wire under_sel = temp_input ? below_nom : below_perm;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			live_q <= mdp_pkg::ZERO16;
			upper_q <= 1'b0;
			under_q <= 1'b0;
		end else if (meas_vld) begin
			live_q <= meas_val;
			upper_q <= over_sel;
			under_q <= under_sel & ~over_sel;
		end
	end

	assign pk.smp_vld = meas_vld & ~over_sel & ~under_sel & ~fault_q;
	assign pk.smp_val = meas_val;
	assign pk.swing = swing_q;
	mdp_peak u_peak (
		.clk(clk),
		.rst_n(rst_n),
		.pk(pk)
	);

	// ------------------------------------------------------------
	// Peak show timer
	// ------------------------------------------------------------
	logic showing_q;
	logic signed [15:0] held_q;
	logic [15:0] show_cnt_q;
	wire zero_show = (show_q == mdp_pkg::ZERO16);
	wire hold_off = zero_show & ~hold_mode_q;
	wire show_done = deci_tick && !zero_show && (show_cnt_q + 16'h0001 >= show_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			showing_q <= 1'b0;
			held_q <= mdp_pkg::ZERO16;
			show_cnt_q <= mdp_pkg::ZERO16;
		end else if (pk.peak_stb && !hold_off) begin
			showing_q <= 1'b1;
			held_q <= pk.peak_val;
			show_cnt_q <= mdp_pkg::ZERO16;
		end else if (hold_off || (zero_show && key_esc)) begin
			showing_q <= 1'b0;
		end else if (show_done) begin
			showing_q <= 1'b0;
		end else if (showing_q && deci_tick) begin
			show_cnt_q <= show_cnt_q + 16'h0001;
		end
	end

	wire signed [15:0] relay_sel = relay_src_q ? held_q : live_q;

	// ------------------------------------------------------------
	// Threshold browsing
	// ------------------------------------------------------------
	mdp_pkg::mdp_browse_t br_q, br_d;
	logic [7:0] thr_idx_q;
	logic [12:0] key_ms_q;
	wire arrow = key_up | key_down;
	wire key_expired = ms_tick && (key_ms_q + 13'd1 >= 13'(KEY_TIMEOUT_MS));
	wire [7:0] thr_next = (thr_idx_q == 8'(NUM_THR - 1)) ? 8'd0 : thr_idx_q + 8'd1;

	always_comb begin
		br_d = br_q;
		case (br_q)
			mdp_pkg::MDP_BR_IDLE: if (arrow) br_d = mdp_pkg::MDP_BR_SHOW;
			mdp_pkg::MDP_BR_SHOW: begin
				if (key_enter && free_acc_q)
					br_d = mdp_pkg::MDP_BR_EDIT;
				else if (key_esc || (key_expired && !arrow))
					br_d = mdp_pkg::MDP_BR_IDLE;
			end
			mdp_pkg::MDP_BR_EDIT: if (key_enter || key_esc) br_d = mdp_pkg::MDP_BR_IDLE;
			default: br_d = mdp_pkg::MDP_BR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			br_q <= mdp_pkg::MDP_BR_IDLE;
			thr_idx_q <= '0;
			key_ms_q <= '0;
		end else begin
			br_q <= br_d;
			if (br_q == mdp_pkg::MDP_BR_IDLE && arrow) begin
				thr_idx_q <= '0;
				key_ms_q <= '0;
			end else if (br_q == mdp_pkg::MDP_BR_SHOW && arrow) begin
				thr_idx_q <= thr_next;
				key_ms_q <= '0;
			end else if (ms_tick) begin
				key_ms_q <= key_expired ? 13'd0 : key_ms_q + 13'd1;
			end
		end
	end
	assign edit_active = (br_q == mdp_pkg::MDP_BR_EDIT);

	// ------------------------------------------------------------
	// Display selection
	// ------------------------------------------------------------
	function automatic logic fits(input logic signed [15:0] v);
		return (v >= mdp_pkg::DISP_MIN) && (v <= mdp_pkg::DISP_MAX);
	endfunction

	wire browsing = (br_q != mdp_pkg::MDP_BR_IDLE);
	wire signed [15:0] thr_sel = thr_values[thr_idx_q * 16 +: 16];
	wire signed [15:0] shown = showing_q ? held_q : live_q;
	logic [2:0] msg_d;
	logic signed [15:0] val_d;

	always_comb begin
		val_d = shown;
		if (fault_q)
			msg_d = mdp_pkg::MSG_SENSOR;
		else if (upper_q)
			msg_d = mdp_pkg::MSG_UPPER;
		else if (under_q)
			msg_d = mdp_pkg::MSG_UNDER;
		else if (browsing) begin
			// Label and value alternate at the blink rate; edit mode shows the value only
			msg_d = (blink_q && !edit_active) ? mdp_pkg::MSG_LABEL : mdp_pkg::MSG_VALUE;
			val_d = thr_sel;
		end else if (!fits(shown))
			msg_d = mdp_pkg::MSG_EXCESS;
		else
			msg_d = mdp_pkg::MSG_VALUE;
	end

	wire peak_on_disp = showing_q && !browsing && !fault_q && !upper_q && !under_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_msg <= mdp_pkg::MSG_VALUE;
			disp_val <= mdp_pkg::ZERO16;
			dp_right <= 1'b0;
			peak_shown <= 1'b0;
			relay_val <= mdp_pkg::ZERO16;
		end else begin
			disp_msg <= msg_d;
			disp_val <= val_d;
			dp_right <= peak_on_disp & blink_q;
			peak_shown <= peak_on_disp;
			relay_val <= relay_sel;
		end
	end
	assign disp_thr_idx = thr_idx_q;

	// ------------------------------------------------------------
	// Heating and cooling loops
	// ------------------------------------------------------------
	wire loop_step = meas_vld & ~fault_q;

	mdp_pid u_heat (
		.clk(clk), .rst_n(rst_n), .step(loop_step), .cooling(1'b0),
		.target(target_q),
		.measured(meas_val), .kp(kp_h_q), .ki(ki_h_q), .kd(kd_h_q), .drive(heat_drive)
	);

	mdp_pid u_cool (
		.clk(clk), .rst_n(rst_n), .step(loop_step), .cooling(1'b1),
		.target(target_q),
		.measured(meas_val), .kp(kp_c_q), .ki(ki_c_q), .kd(kd_c_q), .drive(cool_drive)
	);
endmodule

// ==== test/mdp_assertions.sv ====
module mdp_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic meas_vld,
	input wire logic above_perm,
	input wire logic below_perm,
	input wire logic above_nom,
	input wire logic temp_input,
	input wire logic wire_open,
	input wire logic key_enter,
	input wire logic key_esc,
	input wire logic [2:0] disp_msg,
	input wire logic dp_right,
	input wire logic peak_shown,
	input wire logic edit_active,
	input wire logic sensor_fault
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Fault and range messages
	// ----------------------------------------
	open_fault_a: assert property (wire_open |-> ##[1:2] sensor_fault)
		else $error("open wire not flagged");
	fault_shown_a: assert property (sensor_fault [*3] |-> disp_msg == mdp_pkg::MSG_SENSOR)
		else $error("fault not on display");
	upper_shown_a: assert property (
		meas_vld && above_perm && !temp_input && !wire_open ##1 !wire_open [*2]
		|-> disp_msg == mdp_pkg::MSG_UPPER)
		else $error("upper overflow not shown");
	under_shown_a: assert property (
		meas_vld && below_perm && !above_perm && !temp_input && !wire_open
		##1 !wire_open [*2] |-> disp_msg == mdp_pkg::MSG_UNDER)
		else $error("under range not shown");
	temp_range_a: assert property (
		meas_vld && temp_input && above_nom && !wire_open ##1 !wire_open [*2]
		|-> disp_msg == mdp_pkg::MSG_UPPER)
		else $error("temperature range not applied");

	// ----------------------------------------
	// Peak point and threshold editing
	// ----------------------------------------
	// A few cycles of slack: the point register follows the peak state
	dp_dark_a: assert property (!peak_shown [*3] |-> !dp_right)
		else $error("point lit without peak");
	edit_cause_a: assert property (
		$rose(edit_active) |-> $past(key_enter) || $past(key_enter, 2))
		else $error("edit opened without enter");
	esc_exit_a: assert property (edit_active && key_esc |-> ##[1:2] !edit_active)
		else $error("edit kept after escape");
endmodule

bind mdp_top mdp_checker i_mdp_checker (
	.clk, .rst_n, .meas_vld, .above_perm, .below_perm, .above_nom, .temp_input,
	.wire_open, .key_enter, .key_esc, .disp_msg, .dp_right, .peak_shown, .edit_active,
	.sensor_fault
);

// ==== test/mdp_conv_model.sv ====
module mdp_conv_model #(
	parameter int PERIOD = 50
) (
	input wire logic clk,
	input wire logic run,
	input wire logic signed [15:0] level,
	input wire logic over,
	input wire logic under,
	output logic meas_vld,
	output logic signed [15:0] meas_val,
	output logic above_perm,
	output logic below_perm,
	output logic above_nom,
	output logic below_nom
);
	timeunit 1ns;
	timeprecision 100ps;

	int cnt = 0;

	initial begin
		meas_vld = 1'b0;
		meas_val = 16'h0000;
		above_perm = 1'b0;
		below_perm = 1'b0;
		above_nom = 1'b0;
		below_nom = 1'b0;
	end

	// One result per period while running; silence models a dead sensor
	always @(negedge clk) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		meas_vld <= run && cnt == 0;
		if (run && cnt == 0) begin
			meas_val <= level;
			above_perm <= over;
			below_perm <= under;
			above_nom <= over;
			below_nom <= under;
		end else begin
			// Inverted outside the strobe, so a late sampler sees the old value only on every other cycle
			meas_val <= ~meas_val;
		end
	end
endmodule

// ==== test/mdp_top_tb.sv ====
module mdp_top_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic run = 1'b0;
	logic over = 1'b0;
	logic under = 1'b0;
	logic temp_input = 1'b0;
	logic wire_open = 1'b0;
	logic slow_terminal = 1'b0;
	logic signed [15:0] level = 16'h0000;
	logic [3:0] keys = 4'h0;
	logic local_wr = 1'b0;
	logic remote_wr = 1'b0;
	logic [3:0] local_addr = 4'h0;
	logic [3:0] remote_addr = 4'h0;
	logic [15:0] local_data = 16'h0000;
	logic [15:0] remote_data = 16'h0000;
	logic tune_load = 1'b0;
	logic tune_cooling = 1'b0;
	logic [15:0] tune_k = 16'h0000;
	logic [63:0] thr = 64'h0104_0103_0102_0101;
	logic meas_vld, above_perm, below_perm, above_nom, below_nom;
	logic signed [15:0] meas_val, disp_val, relay_val;
	logic [2:0] disp_msg;
	logic [7:0] disp_thr_idx;
	logic dp_right, peak_shown, edit_active, sensor_fault, dp_last;
	logic [15:0] heat_drive, cool_drive;
	int err_total = 0;
	int checked = 0;
	int flips = 0;
	int labels = 0;

	// Short time base: 10 cycles per ms, timeouts 20/30/60 ms
	mdp_top #(.TICK_CYCLES(10), .KEY_TIMEOUT_MS(20), .WB_FAST_MS(30), .WB_SLOW_MS(60)) i_mdp_top (
		.clk, .rst_n, .meas_vld, .meas_val, .above_perm, .below_perm, .above_nom,
		.below_nom, .temp_input, .wire_open, .slow_terminal, .key_up(keys[0]),
		.key_down(keys[1]), .key_enter(keys[2]), .key_esc(keys[3]), .thr_values(thr),
		.local_wr, .local_addr, .local_data, .remote_wr, .remote_addr, .remote_data,
		.tune_load, .tune_cooling, .tune_kp(tune_k), .tune_ki(tune_k), .tune_kd(tune_k),
		.disp_msg, .disp_val, .disp_thr_idx, .dp_right, .peak_shown, .edit_active,
		.sensor_fault, .relay_val, .heat_drive, .cool_drive
	);

	mdp_conv_model #(.PERIOD(50)) i_mdp_conv_model (
		.clk, .run, .level, .over, .under, .meas_vld, .meas_val, .above_perm,
		.below_perm, .above_nom, .below_nom
	);

	always #12.5 clk = ~clk;

	always @(negedge clk) begin
		if (peak_shown === 1'b1 && dp_right !== dp_last) flips++;
		if (disp_msg === mdp_pkg::MSG_LABEL) labels++;
		dp_last = dp_right;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic ck(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic cfg(input logic rem, input logic [3:0] a, input logic [15:0] d);
		@(negedge clk);
		remote_wr <= rem;
		local_wr <= !rem;
		remote_addr <= a;
		local_addr <= a;
		remote_data <= d;
		local_data <= d;
		@(negedge clk);
		remote_wr <= 1'b0;
		local_wr <= 1'b0;
	endtask

	// Two full sample periods so the new level is surely on display
	task automatic lvl(input logic signed [15:0] v);
		level <= v;
		idle(120);
	endtask

	task automatic key(input logic [3:0] k);
		@(negedge clk);
		keys <= k;
		@(negedge clk);
		keys <= 4'h0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic sc_ranges();
		logic [23:0] rows [7] = '{24'h81_0064, 24'h42_0064, 24'h03_2710, 24'h03_FC18,
			24'h00_270F, 24'h00_FC19, 24'hA1_0064};
		cfg(1'b1, mdp_pkg::CFG_SHOW, 16'h0000);
		foreach (rows[i]) begin
			over <= rows[i][23];
			under <= rows[i][22];
			temp_input <= rows[i][21];
			lvl(rows[i][15:0]);
			ck(16'(disp_msg), 16'(rows[i][19:16]));
			if (rows[i][19:16] == 4'h0) ck(disp_val, rows[i][15:0]);
		end
		over <= 1'b0;
		temp_input <= 1'b0;
	endtask

	task automatic sc_fault();
		run <= 1'b0;
		idle(200);
		ck(16'(sensor_fault), 16'h0000);
		idle(160);
		ck(16'(sensor_fault), 16'h0001);
		ck(16'(disp_msg), 16'(mdp_pkg::MSG_SENSOR));
		slow_terminal <= 1'b1;
		run <= 1'b1;
		idle(60);
		ck(16'(sensor_fault), 16'h0000);
		run <= 1'b0;
		idle(500);
		ck(16'(sensor_fault), 16'h0000);
		idle(160);
		ck(16'(sensor_fault), 16'h0001);
		run <= 1'b1;
		idle(60);
		wire_open <= 1'b1;
		idle(4);
		ck(16'(disp_msg), 16'(mdp_pkg::MSG_SENSOR));
		wire_open <= 1'b0;
		idle(60);
		ck(16'(sensor_fault), 16'h0000);
	endtask

	task automatic sc_browse();
		lvl(16'h0007);
		ck(relay_val, 16'h0007);
		key(4'h1);
		idle(3);
		ck(disp_val, 16'h0101);
		idle(150);
		key(4'h2);
		idle(180);
		ck(16'(disp_thr_idx), 16'h0001);
		ck(disp_val, 16'h0102);
		idle(60);
		ck(disp_val, 16'h0007);
		key(4'h1);
		key(4'h4);
		idle(2);
		ck(16'(edit_active), 16'h0000);
		@(negedge clk);
		local_wr <= 1'b1;
		remote_wr <= 1'b1;
		local_addr <= mdp_pkg::CFG_FREE_ACC;
		remote_addr <= mdp_pkg::CFG_FREE_ACC;
		local_data <= 16'h0001;
		remote_data <= 16'h0000;
		@(negedge clk);
		local_wr <= 1'b0;
		remote_wr <= 1'b0;
		key(4'h4);
		idle(2);
		ck(16'(edit_active), 16'h0000);
		cfg(1'b0, mdp_pkg::CFG_FREE_ACC, 16'h0001);
		key(4'h4);
		idle(2);
		ck(16'(edit_active), 16'h0001);
		key(4'h8);
		key(4'h8);
		idle(250);
		// Browse longer than one blink half period so the label must appear
		repeat (36) begin
			key(4'h1);
			idle(150);
		end
		idle(250);
		ck(16'(labels != 0), 16'h0001);
		ck(16'(disp_msg), 16'(mdp_pkg::MSG_VALUE));
	endtask

	task automatic sc_peak();
		cfg(1'b1, mdp_pkg::CFG_SHOW, 16'h000A);
		cfg(1'b1, mdp_pkg::CFG_RELAY_SRC, 16'h0001);
		cfg(1'b0, mdp_pkg::CFG_SWING, 16'h0014);
		lvl(16'h001A);
		lvl(16'h0008);
		ck(16'(peak_shown), 16'h0000);
		lvl(16'h003C);
		lvl(16'h0028);
		ck(disp_val, 16'h003C);
		idle(6000);
		lvl(16'h005A);
		lvl(16'h0046);
		idle(8000);
		ck(disp_val, 16'h005A);
		ck(relay_val, 16'h005A);
		idle(4000);
		ck(16'(peak_shown), 16'h0000);
		ck(disp_val, 16'h0046);
		ck(16'(flips >= 2), 16'h0001);
	endtask

	task automatic sc_hold();
		cfg(1'b1, mdp_pkg::CFG_SHOW, 16'h0000);
		cfg(1'b1, mdp_pkg::CFG_HOLD_MODE, 16'h0001);
		lvl(16'h0078);
		lvl(16'h0064);
		idle(3000);
		ck(disp_val, 16'h0078);
		key(4'h8);
		idle(3);
		ck(16'(peak_shown), 16'h0000);
		cfg(1'b1, mdp_pkg::CFG_HOLD_MODE, 16'h0000);
		lvl(16'h0096);
		lvl(16'h0082);
		ck(16'(peak_shown), 16'h0000);
	endtask

	task automatic sc_pid();
		ck(heat_drive | cool_drive, 16'h0000);
		cfg(1'b1, mdp_pkg::CFG_TARGET, 16'h03E8);
		cfg(1'b1, mdp_pkg::CFG_KP_H, 16'h0100);
		cfg(1'b1, mdp_pkg::CFG_KP_C, 16'h0100);
		lvl(16'h0000);
		ck(16'(heat_drive != 16'h0000), 16'h0001);
		ck(cool_drive, 16'h0000);
		lvl(16'h07D0);
		ck(heat_drive, 16'h0000);
		ck(16'(cool_drive != 16'h0000), 16'h0001);
		tune_cooling <= 1'b1;
		tune_load <= 1'b1;
		@(negedge clk);
		tune_load <= 1'b0;
		idle(120);
		ck(cool_drive, 16'h0000);
		lvl(16'h0000);
		ck(16'(heat_drive != 16'h0000), 16'h0001);
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic give_verdict();
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		idle(2);
		rst_n <= 1'b1;
		idle(2);
		ck(16'(disp_msg), 16'h0000);
		run <= 1'b1;
		sc_ranges();
		sc_fault();
		sc_browse();
		sc_peak();
		sc_hold();
		sc_pid();
		give_verdict();
	end

	// About 31k cycles expected; over twice that means a hang
	initial begin
		#2ms;
		err_total++;
		give_verdict();
	end
endmodule
